/* File: ssf_pkg.sv */
// Constants and types of the system status flag block.
// Assumes a host register port that is already decoded into word addresses.
package ssf_pkg;

  // ==========================================================
  // Register word addresses
  localparam logic [15:0] SSF_ADDR_STATE = 16'h03e6;
  localparam logic [15:0] SSF_ADDR_FLAGS = 16'h03e7;
  localparam logic [15:0] SSF_ADDR_LINK_ERR = 16'h03e8;
  localparam logic [15:0] SSF_ADDR_FATAL_ERR = 16'h03e9;
  localparam logic [15:0] SSF_ADDR_CMD = 16'h07cf;

  // ==========================================================
  // Positions of the bits of the flag word
  localparam int SSF_BIT_READY = 0;
  localparam int SSF_BIT_FATAL = 1;
  localparam int SSF_BIT_CONNECTED = 2;
  localparam int SSF_BIT_STACK_FAULT = 3;
  localparam int SSF_BIT_INBOX = 4;
  localparam int SSF_BIT_OUTBOX = 5;
  localparam int SSF_BIT_BUS_ON = 6;
  localparam int SSF_BIT_STORED = 7;
  localparam int SSF_BIT_LOCK = 8;
  localparam int SSF_BIT_SUPERVISOR = 9;

  // ==========================================================
  // Positions of the bits of the command word
  localparam int SSF_CMD_ERASE = 3;
  localparam int SSF_CMD_SAVE = 4;
  localparam int SSF_CMD_LOCK = 5;
  localparam int SSF_CMD_UNLOCK = 6;
  localparam int SSF_CMD_SUP_ON = 7;
  localparam int SSF_CMD_SUP_OFF = 8;

  // ==========================================================
  // Value after reset and mask of all state codes
  localparam logic [15:0] SSF_WORD_RST = 16'h0000;
  localparam logic [4:0] SSF_STATE_MASK_ALL = 5'h1f;

  // Network communication state codes.
  typedef enum logic [2:0] {
    link_state_unknown = 3'h0,
    link_state_offline = 3'h1,
    link_state_stop = 3'h2,
    link_state_idle = 3'h3,
    link_state_operate = 3'h4
  } ssf_link_state_t;

  // Phases of the command executor.
  typedef enum logic [0:0] {
    SSF_EXEC_IDLE = 1'b0,
    SSF_EXEC_RUN = 1'b1
  } ssf_exec_t;

endpackage

/* File: ssf_cmd_if.sv */
// Carrier between the status block and its command executor.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ssf_cmd_if;
  logic [15:0] wr_word;
  logic wr_valid;
  logic [15:0] pending;
  logic erase_setup_cmd;
  logic save_setup_cmd;
  logic lock_cmd;
  logic unlock_cmd;
  logic supervisor_enable_cmd;
  logic supervisor_disable_cmd;

  // The status block writes commands and receives one-cycle pulses.
  modport issuer (
    output wr_word, wr_valid,
    input pending, erase_setup_cmd, save_setup_cmd, lock_cmd, unlock_cmd,
    input supervisor_enable_cmd, supervisor_disable_cmd
  );

  // The executor holds the command word and issues the pulses.
  modport executor (
    input wr_word, wr_valid,
    output pending, erase_setup_cmd, save_setup_cmd, lock_cmd, unlock_cmd,
    output supervisor_enable_cmd, supervisor_disable_cmd
  );
endinterface

/* File: ssf_cmd_exec.sv */
// Command executor: holds the command word and clears it once carried out.
// Assumes writes arrive from the status block on the same clock.
`timescale 1ns/1ns
module ssf_cmd_exec
  import ssf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Command carrier
  ssf_cmd_if.executor cmd
);

  logic [15:0] pending;
  logic [15:0] next_pending;
  ssf_exec_t phase;
  ssf_exec_t next_phase;

  // ==========================================================
  // Next state: a nonzero write is held, carried out next cycle, cleared.
  always_comb begin
    next_pending = pending;
    next_phase = phase;
    case (phase)
      SSF_EXEC_IDLE: begin
        next_phase = SSF_EXEC_IDLE;
      end
      SSF_EXEC_RUN: begin
        next_pending = SSF_WORD_RST;
        next_phase = SSF_EXEC_IDLE;
      end
      default: begin
        next_phase = SSF_EXEC_IDLE;
      end
    endcase
    // A new write wins over the self-clear; a zero word is ignored.
    if (cmd.wr_valid && cmd.wr_word != SSF_WORD_RST) begin
      next_pending = cmd.wr_word;
      next_phase = SSF_EXEC_RUN;
    end
  end

  // Registers of the executor.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pending <= SSF_WORD_RST;
      phase <= SSF_EXEC_IDLE;
    end else begin
      pending <= next_pending;
      phase <= next_phase;
    end
  end

  // Pulses last the one cycle in which the word is carried out.
  assign cmd.pending = pending;
  assign cmd.erase_setup_cmd = (phase == SSF_EXEC_RUN) && pending[SSF_CMD_ERASE];
  assign cmd.save_setup_cmd = (phase == SSF_EXEC_RUN) && pending[SSF_CMD_SAVE];
  assign cmd.lock_cmd = (phase == SSF_EXEC_RUN) && pending[SSF_CMD_LOCK];
  assign cmd.unlock_cmd = (phase == SSF_EXEC_RUN) && pending[SSF_CMD_UNLOCK];
  assign cmd.supervisor_enable_cmd =
    (phase == SSF_EXEC_RUN) && pending[SSF_CMD_SUP_ON];
  assign cmd.supervisor_disable_cmd =
    (phase == SSF_EXEC_RUN) && pending[SSF_CMD_SUP_OFF];

  // ==========================================================
  // Checks of the executor.
  a_cmd_self_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (phase == SSF_EXEC_RUN && !cmd.wr_valid) |=> pending == 16'h0000)
    else $error("command word not cleared after execution");
  a_cmd_zero_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cmd.wr_valid && cmd.wr_word == 16'h0000 && phase == SSF_EXEC_IDLE)
    |=> phase == SSF_EXEC_IDLE)
    else $error("zero command word was executed");
  c_cmd_run: cover property (@(posedge ref_clk) phase == SSF_EXEC_RUN);

endmodule

/* File: ssf_status.sv */
// System status flag block: communication state and flag word for the host.
// Assumes the host interface delivers decoded word reads and writes.
// How it works
// - State register reports codes 0 unknown to 4 operate.
// - Codes outside the supported set report as unknown.
// - Ready rises only after init done and self test passed.
// - System mailbox accepts packets only while ready is set.
// - Connected bit follows the open connection to the network master.
// - Stack fault bit set with its code in the link fault register.
// - Inbox bit set on arrival, cleared when host reads the packet.
// - Outbox bit set on placement, cleared when fieldbus takes packet.
// - Bus bit follows the bus state while the stack accesses the bus.
// - Stored setup bit set by save command, cleared by erase command.
// - On the download variant, a download sets the stored setup bit.
// - Lock bit set by lock command, cleared by unlock command.
// - Supervisor bit set by enable command, cleared by disable command.
// - Command word clears itself once executed; zero is ignored.
`timescale 1ns/1ns
module ssf_status
  import ssf_pkg::*;
#(
  parameter bit FATAL_SUPPORTED = 1'b0,
  parameter bit DOWNLOAD_VARIANT = 1'b0,
  parameter logic [4:0] STATE_SUPPORT = SSF_STATE_MASK_ALL
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // System mailbox
  input wire logic sysmbx_req,
  output logic sysmbx_accept,
  // Operating system events
  input wire logic os_init_done,
  input wire logic self_test_pass,
  input wire logic fatal_detect,
  input wire logic [15:0] fatal_code_in,
  // Protocol stack events
  input wire logic [2:0] link_state_in,
  input wire logic master_connected,
  input wire logic stack_fault_in,
  input wire logic [15:0] stack_fault_code,
  input wire logic bus_access,
  input wire logic bus_state,
  // Mailbox events
  input wire logic inbox_arrive,
  input wire logic inbox_read_out,
  input wire logic outbox_place,
  input wire logic outbox_taken,
  // Configuration download on the download variant
  input wire logic setup_download,
  // Status outputs
  output logic os_halted,
  output logic [15:0] system_flag_word
);

  ssf_cmd_if cmd ();

  logic ready;
  logic fatal_flag;
  logic halted;
  logic connected;
  logic stack_fault_flag;
  logic inbox_occupied;
  logic outbox_occupied;
  logic bus_on;
  logic stored_setup_in_use;
  logic setup_write_lock;
  logic supervisor_active;
  logic [15:0] fatal_fault_code;
  logic [15:0] link_fault_code;
  ssf_link_state_t link_state;
  logic [15:0] rdata;

  logic next_ready;
  logic next_fatal_flag;
  logic next_halted;
  logic next_bus_on;
  logic next_stored;
  logic next_lock;
  logic next_supervisor;
  logic next_inbox;
  logic next_outbox;
  logic [15:0] next_fatal_code;
  logic [15:0] next_link_code;
  ssf_link_state_t next_link_state;
  logic [15:0] next_rdata;
  logic [15:0] flags;

  // ==========================================================
  // Command executor
  ssf_cmd_exec u_exec (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cmd(cmd.executor)
  );

  // Only writes to the command address reach the executor.
  assign cmd.wr_valid = reg_wr && (reg_addr == SSF_ADDR_CMD);
  assign cmd.wr_word = reg_wdata;

  // ==========================================================
  // Next values of the system state and fault codes.
  always_comb begin
    next_ready = ready;
    next_fatal_flag = fatal_flag;
    next_halted = halted;
    next_fatal_code = fatal_fault_code;
    next_link_code = link_fault_code;
    next_link_state = link_state_unknown;
    if (!halted && os_init_done && self_test_pass) begin
      next_ready = 1'b1;
    end
    if (fatal_detect) begin
      next_ready = 1'b0;
      next_halted = 1'b1;
      next_fatal_flag = FATAL_SUPPORTED;
      next_fatal_code = fatal_code_in;
    end
    if (stack_fault_in) begin
      next_link_code = stack_fault_code;
    end
    // Unsupported or undefined codes fall back to unknown.
    if (link_state_in <= 3'h4 && STATE_SUPPORT[link_state_in]) begin
      next_link_state = ssf_link_state_t'(link_state_in);
    end
  end

  // Next values of the mailbox, bus and configuration flags.
  always_comb begin
    next_bus_on = bus_access ? bus_state : bus_on;
    next_inbox = inbox_occupied;
    if (inbox_read_out) begin
      next_inbox = 1'b0;
    end
    if (inbox_arrive) begin
      next_inbox = 1'b1;
    end
    next_outbox = outbox_occupied;
    if (outbox_taken) begin
      next_outbox = 1'b0;
    end
    if (outbox_place) begin
      next_outbox = 1'b1;
    end
    next_stored = stored_setup_in_use;
    if (cmd.erase_setup_cmd) begin
      next_stored = 1'b0;
    end
    if (cmd.save_setup_cmd || (DOWNLOAD_VARIANT && setup_download)) begin
      next_stored = 1'b1;
    end
    next_lock = setup_write_lock;
    if (cmd.unlock_cmd) begin
      next_lock = 1'b0;
    end
    if (cmd.lock_cmd) begin
      next_lock = 1'b1;
    end
    next_supervisor = supervisor_active;
    if (cmd.supervisor_disable_cmd) begin
      next_supervisor = 1'b0;
    end
    if (cmd.supervisor_enable_cmd) begin
      next_supervisor = 1'b1;
    end
  end

  // Flag word as the host sees it; bits 10 to 15 read as zero.
  always_comb begin
    flags = SSF_WORD_RST;
    flags[SSF_BIT_READY] = ready;
    flags[SSF_BIT_FATAL] = fatal_flag;
    flags[SSF_BIT_CONNECTED] = connected;
    flags[SSF_BIT_STACK_FAULT] = stack_fault_flag;
    flags[SSF_BIT_INBOX] = inbox_occupied;
    flags[SSF_BIT_OUTBOX] = outbox_occupied;
    flags[SSF_BIT_BUS_ON] = bus_on;
    flags[SSF_BIT_STORED] = stored_setup_in_use;
    flags[SSF_BIT_LOCK] = setup_write_lock;
    flags[SSF_BIT_SUPERVISOR] = supervisor_active;
  end

  // Read data for the host; unmapped addresses read zero.
  always_comb begin
    next_rdata = rdata;
    if (reg_rd) begin
      case (reg_addr)
        SSF_ADDR_STATE: next_rdata = {13'h0, link_state};
        SSF_ADDR_FLAGS: next_rdata = flags;
        SSF_ADDR_LINK_ERR: next_rdata = link_fault_code;
        SSF_ADDR_FATAL_ERR: next_rdata = fatal_fault_code;
        SSF_ADDR_CMD: next_rdata = cmd.pending;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Registers of the block.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready <= 1'b0;
      fatal_flag <= 1'b0;
      halted <= 1'b0;
      connected <= 1'b0;
      stack_fault_flag <= 1'b0;
      inbox_occupied <= 1'b0;
      outbox_occupied <= 1'b0;
      bus_on <= 1'b0;
      stored_setup_in_use <= 1'b0;
      setup_write_lock <= 1'b0;
      supervisor_active <= 1'b0;
      fatal_fault_code <= SSF_WORD_RST;
      link_fault_code <= SSF_WORD_RST;
      link_state <= link_state_unknown;
      rdata <= SSF_WORD_RST;
      system_flag_word <= SSF_WORD_RST;
    end else begin
      ready <= next_ready;
      fatal_flag <= next_fatal_flag;
      halted <= next_halted;
      connected <= master_connected;
      stack_fault_flag <= stack_fault_in;
      inbox_occupied <= next_inbox;
      outbox_occupied <= next_outbox;
      bus_on <= next_bus_on;
      stored_setup_in_use <= next_stored;
      setup_write_lock <= next_lock;
      supervisor_active <= next_supervisor;
      fatal_fault_code <= next_fatal_code;
      link_fault_code <= next_link_code;
      link_state <= next_link_state;
      rdata <= next_rdata;
      system_flag_word <= flags;
    end
  end

  // The mailbox handshake answers in the same cycle as the request.
  assign sysmbx_accept = sysmbx_req && ready;
  assign reg_rdata = rdata;
  assign os_halted = halted;

  // ==========================================================
  // Checks of the block.
  a_ready_needs_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(ready) |-> $past(os_init_done) && $past(self_test_pass))
    else $error("ready rose without init and self test");
  a_mbx_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sysmbx_req |-> (sysmbx_accept == (ready && !halted)))
    else $error("mailbox acceptance does not follow ready");
  a_fatal_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fatal_detect |=> !ready && halted ##1 !ready)
    else $error("fatal fault did not halt and drop ready");
  a_connected_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    master_connected |=> ##1 system_flag_word[SSF_BIT_CONNECTED])
    else $error("connected bit missing");
  a_inbox_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    inbox_arrive |=> inbox_occupied)
    else $error("inbox bit not set on arrival");
  a_inbox_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (inbox_read_out && !inbox_arrive) |=> !inbox_occupied)
    else $error("inbox bit not cleared after read out");
  a_outbox_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (outbox_taken && !outbox_place) |=> !outbox_occupied)
    else $error("outbox bit not cleared after take over");
  a_bus_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !bus_access |=> $stable(bus_on))
    else $error("bus bit moved without bus access");
  a_lock_cmd: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == SSF_ADDR_CMD && reg_wdata == 16'h0020)
    |=> ##1 setup_write_lock)
    else $error("lock command did not set lock bit");
  a_sup_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == SSF_ADDR_CMD && reg_wdata == 16'h0100)
    |=> ##1 !supervisor_active)
    else $error("disable command did not clear supervisor bit");
  a_save_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd.save_setup_cmd |=> stored_setup_in_use)
    else $error("save command did not set stored setup bit");
  a_flags_ro: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == SSF_ADDR_FLAGS && cmd.pending == 16'h0000
    && !setup_download) |=> $stable(setup_write_lock)
    && $stable(stored_setup_in_use) && $stable(supervisor_active))
    else $error("flag word write changed a command flag");
  a_state_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    link_state_in > 3'h4 |=> link_state == link_state_unknown)
    else $error("undefined state code not reported as unknown");
  c_mbx_taken: cover property (@(posedge ref_clk) sysmbx_accept);
  c_fatal: cover property (@(posedge ref_clk) fatal_detect && ready);
  c_operate: cover property (@(posedge ref_clk)
    link_state == link_state_operate);
  c_inbox_race: cover property (@(posedge ref_clk)
    inbox_arrive && inbox_read_out);

endmodule

/* File: ssf_host_model.sv */
// Host application model that reaches the status block over its word port.
// Assumes the testbench calls its tasks and owns all other block inputs.
`timescale 1ns/1ns
module ssf_host_model
  import ssf_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port towards the block
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Mailbox strobes of the host
  output logic inbox_read_out,
  output logic outbox_place
);
  // ==========================================================
  // Word access
  // The port is idle at time zero.
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    inbox_read_out = 1'b0;
    outbox_place = 1'b0;
  end

  // One read strobe, then the held read data is taken.
  task automatic read_word(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a; // A released address keeps no old value.
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // One write strobe with its word.
  task automatic write_word(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // ==========================================================
  // Mailbox handling
  // Polls the inbox bit, then reads the packet out if one is there.
  task automatic poll_inbox(output logic found);
    logic [15:0] f;
    found = 1'b0;
    for (int i = 0; i < 20 && !found; i++) begin
      read_word(SSF_ADDR_FLAGS, f);
      found = f[SSF_BIT_INBOX];
    end
    if (found) begin
      @(negedge ref_clk);
      inbox_read_out = 1'b1;
      @(negedge ref_clk);
      inbox_read_out = 1'b0;
    end
  endtask

  // Places a packet only while the outbox bit reads zero.
  task automatic send_packet(output logic sent);
    logic [15:0] f;
    read_word(SSF_ADDR_FLAGS, f);
    sent = (f[SSF_BIT_OUTBOX] === 1'b0);
    if (sent) begin
      @(negedge ref_clk);
      outbox_place = 1'b1;
      @(negedge ref_clk);
      outbox_place = 1'b0;
    end
  endtask

  // Input data counts as usable only while the connected bit is set.
  task automatic input_usable(output logic ok);
    logic [15:0] f;
    read_word(SSF_ADDR_FLAGS, f);
    ok = (f[SSF_BIT_CONNECTED] === 1'b1);
  endtask
endmodule

/* File: system_status_flags_test.sv */
// Self-checking testbench of the system status flag block.
// Assumes the host model owns the register port and mailbox strobes.
`timescale 1ns/1ns
module system_status_flags_test
  import ssf_pkg::*;
();
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_rd, reg_wr, inbox_read_out, outbox_place;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, system_flag_word;
  logic sysmbx_req = 1'b1, os_init_done = 1'b0, self_test_pass = 1'b0;
  logic fatal_detect = 1'b0, master_connected = 1'b0;
  logic stack_fault_in = 1'b0, bus_access = 1'b0, bus_state = 1'b0;
  logic inbox_arrive = 1'b0, outbox_taken = 1'b0, setup_download = 1'b0;
  logic [15:0] fatal_code_in = 16'h0000, stack_fault_code = 16'h0000;
  logic [2:0] link_state_in = 3'h0;
  logic sysmbx_accept, os_halted, ok;
  logic [15:0] rd;
  logic [15:0] cmds [8] = '{16'h0010, 16'h0020, 16'h0080, 16'h0008,
                            16'h0040, 16'h0100, 16'h0060, 16'h0040};
  logic [15:0] flags [8] = '{16'h0081, 16'h0181, 16'h0381, 16'h0301,
                             16'h0201, 16'h0001, 16'h0101, 16'h0001};
  int errors = 0;
  int total_checks = 0;

  // The clock toggles every half period of 20 ns.
  always #20 ref_clk = ~ref_clk;

  ssf_status u_ssf_status (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sysmbx_req(sysmbx_req), .sysmbx_accept(sysmbx_accept),
    .os_init_done(os_init_done), .self_test_pass(self_test_pass),
    .fatal_detect(fatal_detect), .fatal_code_in(fatal_code_in),
    .link_state_in(link_state_in), .master_connected(master_connected),
    .stack_fault_in(stack_fault_in), .stack_fault_code(stack_fault_code),
    .bus_access(bus_access), .bus_state(bus_state),
    .inbox_arrive(inbox_arrive), .inbox_read_out(inbox_read_out),
    .outbox_place(outbox_place), .outbox_taken(outbox_taken),
    .setup_download(setup_download), .os_halted(os_halted),
    .system_flag_word(system_flag_word));

  ssf_host_model u_ssf_host_model (.ref_clk(ref_clk), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .inbox_read_out(inbox_read_out),
    .outbox_place(outbox_place));

  // ==========================================================
  // Helpers
  // Compares a word and counts the result.
  task automatic check_word(input string what, input logic [15:0] e,
                            input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // Compares a single bit and counts the result.
  task automatic check_bit(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask

  // Waits a fixed number of falling edges.
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Raises an event input for one cycle.
  task automatic pulse(ref logic sig);
    @(negedge ref_clk);
    sig = 1'b1;
    @(negedge ref_clk);
    sig = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    wait_cycles(4);
    sys_rst = 1'b0;
    wait_cycles(1);
    check_word("flag word after reset", 16'h0000, system_flag_word);
    check_bit("accept before ready", 1'b0, sysmbx_accept);
    $display("test reset done");
    os_init_done = 1'b1;
    wait_cycles(4);
    check_word("flags without self test", 16'h0000, system_flag_word);
    self_test_pass = 1'b1;
    wait_cycles(3);
    check_word("flags when ready", 16'h0001, system_flag_word);
    check_bit("accept when ready", 1'b1, sysmbx_accept);
    sysmbx_req = 1'b0;
    wait_cycles(1);
    check_bit("accept without request", 1'b0, sysmbx_accept);
    sysmbx_req = 1'b1;
    $display("test ready done");
    for (int i = 0; i < 8; i++) begin
      link_state_in = 3'(i);
      wait_cycles(3);
      u_ssf_host_model.read_word(SSF_ADDR_STATE, rd);
      check_word("state", (i <= 4) ? 16'(i) : 16'h0000, rd);
    end
    $display("test state done");
    master_connected = 1'b1;
    stack_fault_in = 1'b1;
    stack_fault_code = 16'h5a3c;
    bus_access = 1'b1;
    bus_state = 1'b1;
    wait_cycles(3);
    check_word("flags link", 16'h004d, system_flag_word);
    u_ssf_host_model.read_word(SSF_ADDR_LINK_ERR, rd);
    check_word("link fault code", 16'h5a3c, rd);
    master_connected = 1'b0;
    stack_fault_in = 1'b0;
    bus_state = 1'b0;
    wait_cycles(3);
    check_word("flags link off", 16'h0001, system_flag_word);
    u_ssf_host_model.input_usable(ok);
    check_bit("input usable", 1'b0, ok);
    bus_access = 1'b0;
    bus_state = 1'b1;
    wait_cycles(3);
    check_word("flags bus held", 16'h0001, system_flag_word);
    $display("test link done");
    pulse(inbox_arrive);
    u_ssf_host_model.poll_inbox(ok);
    check_bit("inbox seen", 1'b1, ok);
    wait_cycles(3);
    check_word("flags inbox read", 16'h0001, system_flag_word);
    u_ssf_host_model.send_packet(ok);
    check_bit("first send", 1'b1, ok);
    wait_cycles(3);
    check_word("flags outbox full", 16'h0021, system_flag_word);
    u_ssf_host_model.send_packet(ok);
    check_bit("second send held", 1'b0, ok);
    pulse(outbox_taken);
    wait_cycles(3);
    check_word("flags outbox taken", 16'h0001, system_flag_word);
    $display("test mailbox done");
    for (int i = 0; i < 8; i++) begin
      u_ssf_host_model.write_word(SSF_ADDR_CMD, cmds[i]);
      wait_cycles(2);
      u_ssf_host_model.read_word(SSF_ADDR_CMD, rd);
      check_word("command pending", 16'h0000, rd);
      u_ssf_host_model.read_word(SSF_ADDR_FLAGS, rd);
      check_word("flags command", flags[i], rd);
    end
    u_ssf_host_model.write_word(SSF_ADDR_CMD, 16'h0000);
    u_ssf_host_model.write_word(SSF_ADDR_FLAGS, 16'hffff);
    wait_cycles(3);
    u_ssf_host_model.read_word(SSF_ADDR_FLAGS, rd);
    check_word("flags after writes", 16'h0001, rd);
    u_ssf_host_model.read_word(16'h0100, rd);
    check_word("unmapped read", 16'h0000, rd);
    pulse(setup_download);
    wait_cycles(3);
    check_word("flags after download", 16'h0001, system_flag_word);
    $display("test command done");
    fatal_code_in = 16'hbeef;
    pulse(fatal_detect);
    wait_cycles(3);
    check_word("flags after fatal", 16'h0000, system_flag_word);
    check_bit("halted", 1'b1, os_halted);
    check_bit("accept after fatal", 1'b0, sysmbx_accept);
    u_ssf_host_model.read_word(SSF_ADDR_FATAL_ERR, rd);
    check_word("fatal code", 16'hbeef, rd);
    $display("test fatal done");
    test_done();
  end

  // Cuts a hang short after about 5000 cycles.
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
